// File: src/sew_pkg.sv
// Purpose: Shared constants for the serial error, wake and interrupt block.
// Assumes: AHB-Lite register access, one 32-bit word per register.
// Notes:   Register bytes sit in bits 7:0, upper bits read as zero.
package sew_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] SEW_OFS_CTRL = 8'h00;
	localparam logic [7:0] SEW_OFS_CSR  = 8'h04;
	localparam logic [7:0] SEW_OFS_DATA = 8'h08;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int SEW_CTRL_IRQ_EN = 7;
	localparam int SEW_CTRL_SPE    = 6;
	localparam int SEW_CTRL_MSTR   = 4;
	localparam int SEW_CTRL_CPOL   = 3;
	localparam int SEW_CTRL_CPHA   = 2;

	// ************************************************************
	// Control/status register fields
	// ************************************************************
	localparam int SEW_CSR_DONE  = 7;
	localparam int SEW_CSR_WRITE_COLLISION_FLAG  = 6;
	localparam int SEW_CSR_OVR   = 5;
	localparam int SEW_CSR_MFLT  = 4;
	localparam int SEW_CSR_SSM   = 1;
	localparam int SEW_CSR_SSI   = 0;

	// ************************************************************
	// Reset values and counts
	// ************************************************************
	localparam logic [7:0] SEW_CTRL_RST = 8'h00;
	localparam logic [1:0] SEW_SEL_RST  = 2'h0;
	localparam logic [7:0] SEW_BYTE_RST = 8'h00;
	localparam logic [2:0] SEW_LAST_BIT = 3'h7;
	localparam logic [3:0] SEW_LAST_TOG = 4'hf;
	localparam int         SEW_HALF_DIV = 8;

	// ************************************************************
	// Bus encodings
	// ************************************************************
	localparam logic [1:0] SEW_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] SEW_HRESP_OKAY    = 2'h0;
endpackage : sew_pkg

// File: src/sew_sync.sv
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module sew_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Levels
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule : sew_sync

// File: src/sew_flag.sv
// Purpose: Sticky flag with a two-step software clearing sequence.
// Assumes: All inputs are one-cycle pulses on hclk.
// Notes:   A set in the clearing cycle wins and disarms the sequence.
`timescale 1ns/1ps
module sew_flag (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Events
	input  wire logic set_i,
	input  wire logic arm_i,
	input  wire logic clr_i,
	// State
	output logic      flag_o,
	output logic      armed_o
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (clr_i && armed_o) begin
			flag_o <= 1'b0;
		end
	end

	// The arm only counts while the flag is up, so an early status
	// read cannot pre-arm a later flag.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_o <= 1'b0;
		end else if (set_i || (clr_i && armed_o)) begin
			armed_o <= 1'b0;
		end else if (arm_i && flag_o) begin
			armed_o <= 1'b1;
		end
	end
endmodule : sew_flag

// File: src/sew_serial.sv
// Purpose: Serial peripheral with error flags, wake-up and interrupt.
// Assumes: Pins are asynchronous to hclk; link clock much slower.
// Notes:   Reads take one wait state, writes none.
// Operation
// RQ1 - Overrun when a byte completes while the done flag is still set.
// RQ2 - Overrun sets its flag and requests an interrupt when enabled.
// RQ3 - On overrun keep the buffered byte, drop later ones, read returns it.
// RQ4 - Reading the control/status register clears the overrun flag.
// RQ5 - Data write during a transfer is ignored; transfer runs on unchanged.
// RQ6 - Write collision is detected in both master and slave mode.
// RQ7 - Write collision sets its flag but never requests an interrupt.
// RQ8 - Receive buffer is read synchronously; no read collision exists.
// RQ9 - In wait mode operation is normal; enabled events wake the processor.
// RQ10 - In halt registers hold, peripheral idles until woken.
// RQ11 - Several bytes received during halt flag an overrun.
// RQ12 - Slave transfer completion raises done and can wake from halt.
// RQ13 - Halt wake-up only if internal select is low at halt entry.
// RQ14 - External master holds select low when the slave enters halt.
// RQ15 - After halt, leaving slave mode ends halt state; else one transfer.
// RQ16 - Only done wakes from halt; fault and overrun wake wait only.
// RQ17 - One shared request, gated by enable and processor mask.
// RQ18 - Master selects one slave at a time over separate select lines; the block drives no select output.
// RQ19 - Without a new write the slave echoes the last received byte.
// RQ20 - Enabled request whenever done, fault or overrun flag is one.
// RQ21 - Done clears after status access while set, then data access.
// RQ22 - While done is set, data writes blocked until status is read; the code also unblocks them after a status write.
// RQ23 - Collision flag clears by status read then data access.
// RQ24 - Reset clears all flags and drops the request.
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module sew_serial #(
	parameter int HALF_DIV = sew_pkg::SEW_HALF_DIV
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic      [1:0]  hresp,
	// Serial pins
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe,
	input  wire logic        ss_n_i,
	// Processor side
	input  wire logic        irq_mask,
	input  wire logic        wait_mode,
	input  wire logic        halt_mode,
	input  wire logic        master_fault_set,
	output logic             irq,
	output logic             wake,
	output logic             halt_state
);
	// ************************************************************
	// Bus slave
	// ************************************************************
	logic [7:0] addr_q;
	logic       rd_q, wr_q;
	logic [7:0] ctrl_q;
	logic [1:0] sel_q;
	logic [7:0] rx_buf_q;
	logic       done_flag, done_armed, write_collision_flag_flag, mflt_flag;
	logic       overrun_flag_q;
	logic       accept;
	logic       csr_rd, csr_acc, data_rd, data_wr, data_acc, ctrl_wr;
	logic [7:0] rd_val;

	assign accept    = hsel && hready && (htrans == sew_pkg::SEW_HTRANS_NONSEQ);
	assign hreadyout = !rd_q;
	assign hresp     = sew_pkg::SEW_HRESP_OKAY;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 8'h00;
			rd_q   <= 1'b0;
			wr_q   <= 1'b0;
		end else begin
			rd_q <= accept && !hwrite;
			wr_q <= accept && hwrite;
			if (accept) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	assign csr_rd   = rd_q && (addr_q == sew_pkg::SEW_OFS_CSR);
	assign csr_acc  = csr_rd || (wr_q && (addr_q == sew_pkg::SEW_OFS_CSR));
	assign data_rd  = rd_q && (addr_q == sew_pkg::SEW_OFS_DATA);
	assign data_wr  = wr_q && (addr_q == sew_pkg::SEW_OFS_DATA);
	assign data_acc = data_rd || data_wr;
	assign ctrl_wr  = wr_q && (addr_q == sew_pkg::SEW_OFS_CTRL);

	always_comb begin
		rd_val = 8'h00;
		unique case (addr_q)
			sew_pkg::SEW_OFS_CTRL: rd_val = ctrl_q;
			sew_pkg::SEW_OFS_CSR: rd_val = {done_flag, write_collision_flag_flag,
				overrun_flag_q, mflt_flag, 2'b00, sel_q};
			sew_pkg::SEW_OFS_DATA: rd_val = rx_buf_q; // RQ3 RQ8
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_q) begin
			hrdata <= {24'h00_0000, rd_val};
		end
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************
	logic irq_en, spe, mstr, cpol, cpha, ss_int;

	// A fault drops enable and master mode; it beats a same-cycle write.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= sew_pkg::SEW_CTRL_RST;
		end else if (master_fault_set) begin
			ctrl_q[sew_pkg::SEW_CTRL_SPE]  <= 1'b0;
			ctrl_q[sew_pkg::SEW_CTRL_MSTR] <= 1'b0;
		end else if (ctrl_wr) begin
			ctrl_q <= hwdata[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_q <= sew_pkg::SEW_SEL_RST;
		end else if (wr_q && (addr_q == sew_pkg::SEW_OFS_CSR)) begin
			sel_q <= hwdata[1:0];
		end
	end

	assign irq_en = ctrl_q[sew_pkg::SEW_CTRL_IRQ_EN];
	assign spe    = ctrl_q[sew_pkg::SEW_CTRL_SPE];
	assign mstr   = ctrl_q[sew_pkg::SEW_CTRL_MSTR];
	assign cpol   = ctrl_q[sew_pkg::SEW_CTRL_CPOL];
	assign cpha   = ctrl_q[sew_pkg::SEW_CTRL_CPHA];

	// ************************************************************
	// Pin inputs and halt capture
	// ************************************************************
	logic [3:0] pins_s;
	logic       sck_s, mosi_s, miso_s, ss_n_s;
	logic       sck_prev_q, halt_prev_q, wake_armed_q;
	logic       slave_act, halt_entry, byte_done;

	sew_sync #(
		.WIDTH (4)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.async_i ({sck_i, mosi_i, miso_i, ss_n_i}),
		.sync_o  (pins_s)
	);

	assign {sck_s, mosi_s, miso_s, ss_n_s} = pins_s;
	assign ss_int = sel_q[sew_pkg::SEW_CSR_SSM] ?
		sel_q[sew_pkg::SEW_CSR_SSI] : ss_n_s;
	assign halt_entry = halt_mode && !halt_prev_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_prev_q   <= 1'b0;
			halt_prev_q  <= 1'b0;
			wake_armed_q <= 1'b0;
		end else begin
			sck_prev_q  <= sck_s;
			halt_prev_q <= halt_mode;
			if (halt_entry) begin
				wake_armed_q <= spe && !mstr && !ss_int; // RQ13
			end else if (!halt_mode) begin
				wake_armed_q <= 1'b0;
			end
		end
	end

	// In halt only an armed slave keeps shifting; all else idles.
	assign slave_act = spe && !mstr && !ss_int &&
		(!halt_mode || wake_armed_q); // RQ10 RQ12

	// ************************************************************
	// Clock generation for master mode
	// ************************************************************
	localparam int DIV_W = $clog2(HALF_DIV + 1);
	logic [DIV_W-1:0] div_q;
	logic [3:0]       tog_q;
	logic             mbusy_q, sck_q, m_tog;
	logic             busy_q, start;

	assign m_tog = mbusy_q && !halt_mode &&
		(div_q == DIV_W'(HALF_DIV - 1)); // RQ10
	assign start = data_wr && mstr && spe && !busy_q && !mbusy_q &&
		(!done_flag || done_armed);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q   <= '0;
			tog_q   <= 4'h0;
			mbusy_q <= 1'b0;
			sck_q   <= 1'b0;
		end else if (start) begin
			mbusy_q <= 1'b1;
			div_q   <= '0;
			tog_q   <= 4'h0;
		end else if (!mbusy_q || !spe || !mstr) begin
			mbusy_q <= 1'b0;
			sck_q   <= cpol;
		end else if (!halt_mode) begin
			div_q <= m_tog ? '0 : div_q + DIV_W'(1);
			if (m_tog) begin
				sck_q <= !sck_q;
				tog_q <= tog_q + 4'h1;
				if (tog_q == sew_pkg::SEW_LAST_TOG) begin
					mbusy_q <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// Shift engine
	// ************************************************************
	logic [7:0] shift_q;
	logic [2:0] bit_q;
	logic       out_q;
	logic       lead, trail, sample, shift_edge, rx_bit, collide;

	always_comb begin
		lead  = 1'b0;
		trail = 1'b0;
		if (mstr) begin
			lead  = m_tog && (sck_q == cpol);
			trail = m_tog && (sck_q != cpol);
		end else if (slave_act) begin
			lead  = ((sck_s ^ cpol) && !(sck_prev_q ^ cpol));
			trail = (!(sck_s ^ cpol) && (sck_prev_q ^ cpol));
		end
	end

	assign sample     = cpha ? trail : lead;
	assign shift_edge = cpha ? lead : trail;
	assign rx_bit     = mstr ? miso_s : mosi_s;
	assign byte_done  = sample && (bit_q == sew_pkg::SEW_LAST_BIT);
	assign collide    = data_wr && (busy_q || mbusy_q); // RQ5 RQ6

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_q <= sew_pkg::SEW_BYTE_RST;
			bit_q   <= 3'h0;
			busy_q  <= 1'b0;
		end else if (!mstr && !slave_act && !halt_mode) begin
			bit_q  <= 3'h0;
			busy_q <= 1'b0;
			if (data_wr && (!done_flag || done_armed)) begin
				shift_q <= hwdata[7:0]; // RQ22
			end
		end else if (start) begin
			shift_q <= hwdata[7:0];
		end else if (sample) begin
			// The shift register keeps the received byte, so it is
			// echoed when software loads nothing new.
			shift_q <= {shift_q[6:0], rx_bit}; // RQ19
			bit_q   <= bit_q + 3'h1;
			busy_q  <= !byte_done;
		end else if (shift_edge && (cpha || (bit_q != 3'h0))) begin
			// A shift edge inside the byte marks it busy; the last sample ends it.
			busy_q <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_q <= 1'b0;
		// A master byte loaded at start must reach the pin before the
		// first clock edge, so with cpha 0 idle tracking runs until the first sample.
		end else if (shift_edge || (!busy_q && !cpha)) begin
			out_q <= shift_q[7];
		end
	end

	assign sck_o   = sck_q;
	assign sck_oe  = spe && mstr;
	assign mosi_o  = out_q;
	assign mosi_oe = spe && mstr;
	assign miso_o  = out_q;
	assign miso_oe = spe && !mstr && !ss_int;

	// ************************************************************
	// Flags and receive buffer
	// ************************************************************
	logic ovr_evt;

	assign ovr_evt = byte_done && done_flag; // RQ1 RQ11

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_buf_q <= sew_pkg::SEW_BYTE_RST;
		end else if (byte_done && !done_flag) begin
			rx_buf_q <= {shift_q[6:0], rx_bit}; // RQ3
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overrun_flag_q <= 1'b0; // RQ24
		end else if (ovr_evt) begin
			overrun_flag_q <= 1'b1; // RQ2
		end else if (csr_rd) begin
			overrun_flag_q <= 1'b0; // RQ4
		end
	end

	sew_flag u_done (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set_i   (byte_done && !done_flag), // RQ12
		.arm_i   (csr_acc),
		.clr_i   (data_acc), // RQ21
		.flag_o  (done_flag),
		.armed_o (done_armed)
	);

	sew_flag u_write_collision_flag (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set_i   (collide),
		.arm_i   (csr_rd),
		.clr_i   (data_acc), // RQ23
		.flag_o  (write_collision_flag_flag),
		.armed_o ()
	);

	sew_flag u_mflt (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set_i   (master_fault_set),
		.arm_i   (csr_rd),
		.clr_i   (ctrl_wr),
		.flag_o  (mflt_flag),
		.armed_o ()
	);

	// ************************************************************
	// Interrupt, wake and halt state
	// ************************************************************
	// The collision flag is left out: it is status only.
	assign irq = irq_en && !irq_mask &&
		(done_flag || mflt_flag || overrun_flag_q); // RQ7 RQ17 RQ20
	assign wake = (wait_mode && irq) ||
		(halt_mode && wake_armed_q && done_flag &&
		irq_en && !irq_mask); // RQ9 RQ16

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			halt_state <= 1'b0;
		end else if (halt_entry) begin
			halt_state <= 1'b1;
		end else if (!halt_mode && (mstr || !spe || byte_done)) begin
			halt_state <= 1'b0; // RQ15
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_done_then_byte;
		done_flag ##0 byte_done;
	endsequence

	a_overrun_sets: assert property (s_done_then_byte |=> overrun_flag_q) // RQ1
		else $error("overrun flag not set");
	a_buffer_kept: assert property (done_flag |=> $stable(rx_buf_q)) // RQ3
		else $error("buffer changed while done set");
	a_ovr_clear: assert property (csr_rd && !ovr_evt |=> !overrun_flag_q) // RQ4
		else $error("overrun not cleared by status read");
	a_coll_ignored: assert property (collide && !sample && !start |=> // RQ5
		$stable(shift_q))
		else $error("colliding write altered shift");
	a_coll_flag: assert property (collide |=> write_collision_flag_flag) // RQ6
		else $error("collision flag not set");
	a_irq_no_write_collision_flag: assert property (write_collision_flag_flag && !done_flag && !mflt_flag && // RQ7
		!overrun_flag_q |-> !irq)
		else $error("collision raised interrupt");
	a_irq_gate: assert property (irq |-> irq_en && !irq_mask) // RQ17
		else $error("interrupt not gated");
	a_irq_any: assert property ((done_flag || overrun_flag_q || mflt_flag) && // RQ20
		irq_en && !irq_mask |-> irq)
		else $error("missing interrupt");
	a_halt_wake: assert property (halt_mode && wake |-> done_flag && // RQ16
		wake_armed_q)
		else $error("halt wake from wrong event");
	a_done_seq: assert property (done_flag && !done_armed && data_acc && // RQ21
		!byte_done |=> done_flag)
		else $error("done cleared without status access");
	a_wr_block: assert property (done_flag && !done_armed && !mstr && // RQ22
		!slave_act && !halt_mode && data_wr |=> $stable(shift_q))
		else $error("blocked write loaded");
	a_echo: assert property (byte_done ##1 (!data_wr)[*2] |-> // RQ19
		shift_q == rx_buf_q || $past(done_flag, 2))
		else $error("received byte not kept for echo");
endmodule : sew_serial

// File: bench/sew_far_end.sv
// Purpose: Far-side controller for the serial link, master or slave role.
// Assumes: Mode 0 timing (cpol 0, cpha 0), one slave, 200 ns link clock as master, 400 ns as slave.
// Notes:   The link clock stands still between frames.
`timescale 1ns/1ps
module sew_far_end (
	// Pins seen from the block
	input  wire logic dut_sck,
	input  wire logic dut_mosi,
	input  wire logic dut_miso,
	// Pins driven towards the block
	output logic      far_sck,
	output logic      far_mosi,
	output logic      far_miso,
	output logic      far_ss_n
);
	logic [7:0] got;
	logic [7:0] got_s;
	logic [7:0] tx_q;

	initial begin
		far_sck  = 1'b0;
		far_mosi = 1'b0;
		far_miso = 1'b0;
		far_ss_n = 1'b1;
		got_s    = 8'h00;
		tx_q     = 8'h00;
	end

	// ************************************************************
	// Master role
	// ************************************************************
	// The select line drops only around our own byte, so one slave is live.
	task automatic send(input logic [7:0] b);
		far_ss_n <= 1'b0;
		far_mosi <= b[7];
		#200;
		for (int i = 7; i >= 0; i--) begin
			far_sck <= 1'b1;
			got[i] = dut_miso;
			#100;
			far_sck <= 1'b0;
			if (i > 0)
				far_mosi <= b[i-1];
			#100;
		end
		far_ss_n <= 1'b1;
		// A released data line must not keep looking like valid data.
		far_mosi <= ~b[0];
	endtask : send

	// A select held low at halt entry lets the slave arm its wake-up.
	task automatic hold_select(input logic lvl);
		far_ss_n <= lvl;
	endtask : hold_select

	// ************************************************************
	// Slave role
	// ************************************************************
	task automatic load(input logic [7:0] b);
		tx_q     = b;
		far_miso <= b[7];
	endtask : load

	always @(negedge dut_sck) begin
		tx_q     <= {tx_q[6:0], ~tx_q[7]};
		far_miso <= tx_q[6];
	end

	always @(posedge dut_sck) begin
		got_s <= {got_s[6:0], dut_mosi};
	end
endmodule : sew_far_end

// File: bench/sew_serial_tb.sv
// Purpose: Self-checking bench for the serial error, wake and irq block.
// Assumes: Far end in mode 0; flags predicted by a small queue model.
// Notes:   Bus tasks follow the AHB-Lite single-transfer handshake.
`timescale 1ns/1ps
module sew_serial_tb;
	logic        hclk, hresetn, hsel, hwrite, hreadyout;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, hresp;
	logic [2:0]  hsize;
	logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic        far_sck, far_mosi, far_miso, far_ss_n;
	logic        sck_w, mosi_w, miso_w;
	logic        irq_mask, wait_mode, halt_mode, mf_set;
	logic        irq, wake, halt_state;
	logic        m_write_collision_flag, m_ovr, m_mf, m_arm, m_warm, m_marm;
	logic [7:0]  m_rx, m_tx, b0, b1;
	logic [7:0]  rxq[$];
	integer      mismatches, checks_done, cycles, seed;

	assign sck_w  = sck_oe ? sck_o : far_sck;
	assign mosi_w = mosi_oe ? mosi_o : far_mosi;
	assign miso_w = miso_oe ? miso_o : far_miso;

	sew_serial dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sck_i(sck_w),
		.sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
		.mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
		.miso_oe(miso_oe), .ss_n_i(far_ss_n), .irq_mask(irq_mask),
		.wait_mode(wait_mode), .halt_mode(halt_mode),
		.master_fault_set(mf_set), .irq(irq), .wake(wake),
		.halt_state(halt_state));

	sew_far_end far (.dut_sck(sck_w), .dut_mosi(mosi_w),
		.dut_miso(miso_w), .far_sck(far_sck), .far_mosi(far_mosi),
		.far_miso(far_miso), .far_ss_n(far_ss_n));

	// ************************************************************
	// Clock, timeout and verdict
	// ************************************************************
	always #12.5 hclk = ~hclk;

	always @(posedge hclk) begin
		cycles = cycles + 1;
		if (cycles == 10000) begin
			mismatches = mismatches + 1;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// ************************************************************
	// Bus cycles and model
	// ************************************************************
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] wd);
		hsel   <= 1'b1;
		htrans <= sew_pkg::SEW_HTRANS_NONSEQ;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic got_byte(input logic [7:0] b);
		if (rxq.size() > 0)
			m_ovr = 1'b1;
		else
			m_rx = b;
		rxq.push_back(b);
	endtask : got_byte

	task automatic csr_rd;
		bus(1'b0, sew_pkg::SEW_OFS_CSR, 8'h00);
		chk("flags", rd[7:4], {rxq.size() > 0, m_write_collision_flag, m_ovr, m_mf});
		m_arm  = rxq.size() > 0;
		m_warm = m_write_collision_flag;
		m_marm = m_mf;
		m_ovr  = 1'b0;
	endtask : csr_rd

	task automatic data_touch;
		if (m_arm)
			rxq.delete();
		if (m_warm)
			m_write_collision_flag = 1'b0;
		m_arm  = 1'b0;
		m_warm = 1'b0;
	endtask : data_touch

	task automatic data_rd;
		bus(1'b0, sew_pkg::SEW_OFS_DATA, 8'h00);
		chk("rx byte", rd, {24'h0, m_rx});
		data_touch();
	endtask : data_rd

	task automatic data_wr(input logic [7:0] b, input logic busy);
		bus(1'b1, sew_pkg::SEW_OFS_DATA, b);
		if (busy)
			m_write_collision_flag = 1'b1;
		else if (rxq.size() == 0 || m_arm)
			m_tx = b;
		data_touch();
	endtask : data_wr

	task automatic frame(input logic [7:0] b);
		far.send(b);
		repeat (4) @(posedge hclk);
		got_byte(b);
	endtask : frame

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		{hclk, hresetn, hsel, hwrite, irq_mask, wait_mode} = 6'h00;
		{halt_mode, mf_set, m_write_collision_flag, m_ovr, m_mf, m_arm} = 6'h00;
		{m_warm, m_marm, m_rx, m_tx} = 18'h0;
		{haddr, hwdata, htrans} = 66'h0;
		hsize = 3'h2;
		{mismatches, checks_done, cycles} = 96'h0;
		seed = 32'hc355;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("irq after reset", irq, 1'b0);
		csr_rd();
		bus(1'b0, sew_pkg::SEW_OFS_CTRL, 8'h00);
		chk("ctrl reset", rd, {24'h0, sew_pkg::SEW_CTRL_RST});
		bus(1'b0, 8'h0c, 8'h00);
		chk("unmapped", rd, 32'h0);
		// Slave on its select pin: echo, blocked write, overrun.
		bus(1'b1, sew_pkg::SEW_OFS_CTRL, 8'hc0);
		bus(1'b1, sew_pkg::SEW_OFS_CSR, 8'h00);
		data_wr(8'h3c, 1'b0);
		b0 = 8'($random(seed));
		b1 = 8'($random(seed));
		frame(b0);
		chk("slave tx", far.got, m_tx);
		chk("irq on done", irq, 1'b1);
		data_wr(8'h77, 1'b0);
		frame(b1);
		chk("echo", far.got, b0);
		csr_rd();
		csr_rd();
		data_rd();
		chk("irq cleared", irq, 1'b0);
		// Slave collision in mid-frame.
		fork
			frame(b1);
			begin
				repeat (30) @(posedge hclk);
				data_wr(8'h99, 1'b1);
			end
		join
		chk("collision echo", far.got, b1);
		csr_rd();
		data_rd();
		csr_rd();
		// Master transfer in wait mode with a collision behind it.
		bus(1'b1, sew_pkg::SEW_OFS_CSR, 8'h03);
		bus(1'b1, sew_pkg::SEW_OFS_CTRL, 8'hd0);
		wait_mode <= 1'b1;
		b0 = 8'($random(seed));
		far.load(b0);
		data_wr(8'h5a, 1'b0);
		data_wr(8'hff, 1'b1);
		@(posedge hclk);
		chk("no irq on collision", irq, 1'b0);
		for (int i = 0; i < 400 && irq !== 1'b1; i++)
			@(posedge hclk);
		got_byte(b0);
		chk("master tx", far.got_s, 8'h5a);
		chk("wait wake", wake, 1'b1);
		irq_mask <= 1'b1;
		@(posedge hclk);
		@(posedge hclk);
		chk("masked irq", irq, 1'b0);
		irq_mask  <= 1'b0;
		wait_mode <= 1'b0;
		csr_rd();
		data_rd();
		// Halt with the select pin held low: fault, then two bytes.
		bus(1'b1, sew_pkg::SEW_OFS_CTRL, 8'hc0);
		bus(1'b1, sew_pkg::SEW_OFS_CSR, 8'h00);
		far.hold_select(1'b0);
		repeat (3) @(posedge hclk);
		halt_mode <= 1'b1;
		repeat (2) @(posedge hclk);
		chk("halt entered", halt_state, 1'b1);
		mf_set <= 1'b1;
		@(posedge hclk);
		mf_set <= 1'b0;
		@(posedge hclk);
		m_mf = 1'b1;
		chk("fault no halt wake", wake, 1'b0);
		chk("fault irq", irq, 1'b1);
		// The fault dropped enable; restore it while the fault stays set.
		bus(1'b1, sew_pkg::SEW_OFS_CTRL, 8'hc0);
		b0 = 8'($random(seed));
		frame(b0);
		chk("halt wake", wake, 1'b1);
		frame(8'h81);
		halt_mode <= 1'b0;
		@(posedge hclk);
		csr_rd();
		data_rd();
		chk("halt state held", halt_state, 1'b1);
		bus(1'b1, sew_pkg::SEW_OFS_CTRL, 8'h90);
		if (m_marm)
			m_mf = 1'b0;
		repeat (2) @(posedge hclk);
		chk("halt state left", halt_state, 1'b0);
		csr_rd();
		end_of_test();
	end
endmodule : sew_serial_tb
